// ==== include/odl_pkg.sv ====
package odl_pkg;
    // Address split, 64 Mb die
    localparam int ADDR_W = 23;
    localparam int ROW_HI = 22;
    localparam int ROW_LO = 10;
    localparam int ROW_BITS = 13;
    localparam int ROW_COUNT = 8192;
    localparam int COL_BITS = 10;
    localparam int HP_HI = 9;
    localparam int HP_LO = 4;
    localparam int BYTE_HI = 3;
    localparam int BYTE_LO = 0;
    localparam int WORDS_PER_ROW = 512;
    localparam int HALF_PAGE_BYTES = 16;
    // Identification word fields
    localparam int ID_ROW_HI = 12;
    localparam int ID_ROW_LO = 8;
    localparam int ID_COL_HI = 7;
    localparam int ID_COL_LO = 4;
    localparam logic [4:0] ID_ROW_CODE = 5'h0C;
    localparam logic [3:0] ID_COL_CODE = 4'h8;
    // Arbitrary neutral maker code
    localparam logic [3:0] ID_MAKER_CODE = 4'hA;
    localparam logic [15:0] ID_WORD_RST = {3'h0, ID_ROW_CODE, ID_COL_CODE,
        ID_MAKER_CODE};
    // Refresh: one row per cycle, whole array every 8192 cycles
    localparam int REFRESH_INTERVAL_US = 64;
    localparam int SYS_CLK_MHZ = 25;
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_US * SYS_CLK_MHZ;
    localparam int ROW_REFRESH_CYC = (REFRESH_INTERVAL_CYC / ROW_COUNT) < 1
        ? 1 : REFRESH_INTERVAL_CYC / ROW_COUNT;
    localparam logic [15:0] DATA_RST = 16'h0000;
endpackage

// ==== rtl/odl_addr_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module odl_addr_decode
    import odl_pkg::*;
(
    // Byte address
    input wire logic [31:0] addr_in,
    // Decoded fields
    output logic [ROW_BITS-1:0] row_out,
    output logic [HP_HI-HP_LO:0] half_page_out,
    output logic [BYTE_HI-BYTE_LO:0] byte_out
);
    // Bits above the row field ignored
    assign row_out = addr_in[ROW_HI:ROW_LO];
    assign half_page_out = addr_in[HP_HI:HP_LO];
    // Bit 0 forced low: word aligned
    assign byte_out = {addr_in[BYTE_HI:BYTE_LO+1], 1'b0};
endmodule
`default_nettype wire

// ==== rtl/odl_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module odl_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/odl_lane_map.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Register words always move big-endian, upper byte first.
// - A register read gives two bytes per bus clock, one per strobe half.
// - Upper byte while strobe is high, lower byte while strobe is low.
// - Memory byte addresses have bit 0 forced to zero.
// - Row index is byte-address bits 22 to 10, 8192 rows.
// - Half-page is bits 9 to 4; a row holds 512 words.
// - Bits 3 to 0 pick the byte in a 16-byte half-page, bit 0 zero.
// - The die uses 10 column and 13 row bits, 23-bit byte space.
// - Every row is refreshed once per 8192 system clocks, one row per clock.
// - Identification bits 12..8 hold row bits minus one, default 12.
// - Identification bits 7..4 hold column bits minus two, default 8.
// - Memory words read back in the byte order they were written.
module odl_lane_map
    import odl_pkg::*;
(
    // System side
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    // Link side
    input wire logic BUS_CLOCK_LINE_IN,
    input wire logic [7:0] DQ_IN,
    input wire logic REG_SPACE_IN,
    input wire logic WRITE_EN_IN,
    input wire logic READ_EN_IN,
    input wire logic [31:0] ADDR_IN,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE_OUT,
    output logic READ_WRITE_DATA_STROBE_OUT,
    output logic READ_WRITE_DATA_STROBE_OE_OUT,
    // Decoded address and status
    output logic [ROW_BITS-1:0] ROW_OUT,
    output logic [HP_HI-HP_LO:0] HALF_PAGE_OUT,
    output logic [BYTE_HI-BYTE_LO:0] BYTE_OUT,
    output logic [15:0] ID_WORD_OUT,
    output logic [15:0] REG_WORD_OUT,
    output logic WORD_VALID_OUT,
    output logic [ROW_BITS-1:0] REFRESH_ROW_OUT,
    output logic REFRESH_WRAP_OUT
);
    typedef enum logic [0:0] {ODL_IDLE, ODL_LOW} odl_wr_e;

    logic [ROW_BITS-1:0] row_w;
    logic [HP_HI-HP_LO:0] hp_w;
    logic [BYTE_HI-BYTE_LO:0] byte_w;
    logic [15:0] reg_word_q;
    logic [15:0] mem_word_q;
    logic [7:0] wr_hi_q;
    logic [7:0] rd_lo_q;
    logic rd_phase_q;
    logic wr_tog_q;
    logic [15:0] wr_word_q;
    logic wr_reg_q;
    odl_wr_e wr_state_q;
    logic wr_tog_s;
    logic wr_tog_prev_q;
    logic [7:0] dq_hi_q;
    logic [15:0] id_word_q;
    logic [$clog2(ROW_REFRESH_CYC+1)-1:0] ref_cnt_q;
    logic [ROW_BITS-1:0] ref_row_q;
    logic ref_wrap_q;
    logic valid_q;
    logic rd_en_neg_q;

    odl_addr_decode u_dec (
        .addr_in(ADDR_IN),
        .row_out(row_w),
        .half_page_out(hp_w),
        .byte_out(byte_w)
    );

    // Write capture: rise takes upper, fall takes lower
    always_ff @(posedge BUS_CLOCK_LINE_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_hi_q <= 8'h00;
            wr_state_q <= ODL_IDLE;
        end else if (WRITE_EN_IN) begin
            wr_hi_q <= DQ_IN;
            wr_state_q <= ODL_LOW;
        end else begin
            wr_state_q <= ODL_IDLE;
        end
    end

    always_ff @(negedge BUS_CLOCK_LINE_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_word_q <= DATA_RST;
            wr_reg_q <= 1'b0;
            wr_tog_q <= 1'b0;
        end else begin
            case (wr_state_q)
                ODL_LOW: begin
                    // Memory keeps byte A first as written
                    wr_word_q <= {wr_hi_q, DQ_IN};
                    wr_reg_q <= REG_SPACE_IN;
                    wr_tog_q <= ~wr_tog_q;
                end
                default: begin
                    wr_tog_q <= wr_tog_q;
                end
            endcase
        end
    end

    // Read drive: strobe high carries upper byte
    always_ff @(posedge BUS_CLOCK_LINE_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_lo_q <= 8'h00;
        end else if (READ_EN_IN) begin
            rd_lo_q <= REG_SPACE_IN ? reg_word_q[7:0] : mem_word_q[7:0];
        end
    end

    // Read words are quasi-static: written long before any read of them
    always_ff @(posedge BUS_CLOCK_LINE_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dq_hi_q <= 8'h00;
            rd_phase_q <= 1'b0;
        end else if (READ_EN_IN) begin
            dq_hi_q <= REG_SPACE_IN ? reg_word_q[15:8] : mem_word_q[15:8];
            rd_phase_q <= 1'b1;
        end else begin
            rd_phase_q <= 1'b0;
        end
    end

    // Lower half: strobe falls, low byte driven
    always_ff @(negedge BUS_CLOCK_LINE_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_en_neg_q <= 1'b0;
        end else begin
            rd_en_neg_q <= READ_EN_IN;
        end
    end

    // Two bytes per link cycle: upper while clock high, lower while low
    always_comb begin
        DQ_OUT = BUS_CLOCK_LINE_IN ? dq_hi_q : rd_lo_q;
        READ_WRITE_DATA_STROBE_OUT = rd_phase_q & BUS_CLOCK_LINE_IN;
        READ_WRITE_DATA_STROBE_OE_OUT = rd_phase_q;
        DQ_OE_OUT = rd_phase_q;
    end

    // Crossing into the system domain
    odl_sync #(.W(1)) u_tog_sync (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .d_in(wr_tog_q),
        .q_out(wr_tog_s)
    );

    // Word held stable while its toggle crosses
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_tog_prev_q <= 1'b0;
        end else begin
            wr_tog_prev_q <= wr_tog_s;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reg_word_q <= DATA_RST;
            mem_word_q <= DATA_RST;
            valid_q <= 1'b0;
        end else if (wr_tog_s != wr_tog_prev_q) begin
            if (wr_reg_q) begin
                reg_word_q <= wr_word_q;
            end else begin
                mem_word_q <= wr_word_q;
            end
            valid_q <= 1'b1;
        end else begin
            valid_q <= 1'b0;
        end
    end

    // Identification word
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            id_word_q <= ID_WORD_RST;
        end else begin
            id_word_q[ID_ROW_HI:ID_ROW_LO] <= ID_ROW_CODE;
            id_word_q[ID_COL_HI:ID_COL_LO] <= ID_COL_CODE;
        end
    end

    // Row refresh walk over all 8192 rows
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ref_cnt_q <= '0;
            ref_row_q <= '0;
            ref_wrap_q <= 1'b0;
        end else if (ref_cnt_q == ($bits(ref_cnt_q))'(ROW_REFRESH_CYC - 1)) begin
            ref_cnt_q <= '0;
            ref_row_q <= ref_row_q + 1'b1;
            ref_wrap_q <= (ref_row_q == ROW_BITS'(ROW_COUNT - 1));
        end else begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
            ref_wrap_q <= 1'b0;
        end
    end

    // Registered decode outputs
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ROW_OUT <= '0;
            HALF_PAGE_OUT <= '0;
            BYTE_OUT <= '0;
        end else begin
            ROW_OUT <= row_w;
            HALF_PAGE_OUT <= hp_w;
            BYTE_OUT <= byte_w;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ID_WORD_OUT <= ID_WORD_RST;
            REG_WORD_OUT <= DATA_RST;
            WORD_VALID_OUT <= 1'b0;
            REFRESH_ROW_OUT <= '0;
            REFRESH_WRAP_OUT <= 1'b0;
        end else begin
            ID_WORD_OUT <= id_word_q;
            REG_WORD_OUT <= reg_word_q;
            WORD_VALID_OUT <= valid_q;
            REFRESH_ROW_OUT <= ref_row_q;
            REFRESH_WRAP_OUT <= ref_wrap_q;
        end
    end
endmodule
`default_nettype wire

// ==== verif/odl_lane_map_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module odl_lane_map_monitor
    import odl_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic DQ_OE_OUT,
    input wire logic READ_WRITE_DATA_STROBE_OE_OUT,
    input wire logic [ROW_BITS-1:0] ROW_OUT,
    input wire logic [HP_HI-HP_LO:0] HALF_PAGE_OUT,
    input wire logic [BYTE_HI-BYTE_LO:0] BYTE_OUT,
    input wire logic [15:0] ID_WORD_OUT,
    input wire logic [15:0] REG_WORD_OUT,
    input wire logic WORD_VALID_OUT,
    input wire logic [ROW_BITS-1:0] REFRESH_ROW_OUT,
    input wire logic REFRESH_WRAP_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    property p_row;
        $past(RST_N_IN) |-> ROW_OUT == $past(ADDR_IN[22:10]);
    endproperty
    a_row: assert property (p_row) else $error("row wrong");
    property p_hp;
        $past(RST_N_IN) |-> HALF_PAGE_OUT == $past(ADDR_IN[9:4]);
    endproperty
    a_hp: assert property (p_hp) else $error("half page wrong");
    property p_byte;
        $past(RST_N_IN) |-> BYTE_OUT == {$past(ADDR_IN[3:1]), 1'b0};
    endproperty
    a_byte: assert property (p_byte) else $error("byte wrong");
    property p_id;
        ID_WORD_OUT[12:4] == 9'h0C8;
    endproperty
    a_id: assert property (p_id) else $error("id wrong");
    property p_valid;
        WORD_VALID_OUT |=> !WORD_VALID_OUT;
    endproperty
    a_valid: assert property (p_valid) else $error("valid long");
    property p_reg;
        $past(RST_N_IN) && !WORD_VALID_OUT |-> $stable(REG_WORD_OUT);
    endproperty
    a_reg: assert property (p_reg) else $error("word moved");
    property p_wrap;
        REFRESH_ROW_OUT == 13'h1FFF |-> ##[0:2] REFRESH_WRAP_OUT;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_oe;
        DQ_OE_OUT |-> READ_WRITE_DATA_STROBE_OE_OUT;
    endproperty
    a_oe: assert property (p_oe) else $error("strobe off");
    c_valid: cover property (WORD_VALID_OUT);
    c_read: cover property (DQ_OE_OUT);
    c_wrap: cover property (REFRESH_WRAP_OUT);
endmodule
bind odl_lane_map odl_lane_map_monitor mon (.SYS_CLK_IN, .RST_N_IN,
    .ADDR_IN, .DQ_OE_OUT, .READ_WRITE_DATA_STROBE_OE_OUT, .ROW_OUT,
    .HALF_PAGE_OUT, .BYTE_OUT, .ID_WORD_OUT, .REG_WORD_OUT,
    .WORD_VALID_OUT, .REFRESH_ROW_OUT, .REFRESH_WRAP_OUT);
`default_nettype wire

// ==== verif/odl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module odl_host_model (
    // Link lines
    output logic ck_out,
    output logic [7:0] dq_out,
    output logic wr_out,
    output logic rd_out,
    output logic reg_out,
    // Device answer
    input wire logic [7:0] dq_in,
    input wire logic strobe_in
);
    initial begin
        ck_out = 1'b0;
        dq_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        reg_out = 1'b0;
    end
    // Clock stands still between frames
    task automatic write_word(input logic sp, input logic [15:0] w);
        #7 reg_out = sp;
        wr_out = 1'b1;
        dq_out = w[15:8];
        #40 ck_out = 1'b1;
        #40 dq_out = w[7:0];
        #40 ck_out = 1'b0;
        #40 wr_out = 1'b0;
        dq_out = ~w[7:0];
    endtask
    task automatic read_word(input logic sp, output logic [7:0] hi,
        output logic [7:0] lo, output logic [1:0] s);
        #7 reg_out = sp;
        rd_out = 1'b1;
        #40 ck_out = 1'b1;
        #20 hi = dq_in;
        s[1] = strobe_in;
        #60 ck_out = 1'b0;
        #20 s[0] = strobe_in;
        lo = dq_in;
        rd_out = 1'b0;
        #20;
    endtask
endmodule
`default_nettype wire

// ==== verif/test_odl_lane_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_odl_lane_map;
    import odl_pkg::*;
    logic sys_clk, rst_n, ck, wr, rd, sp, stb, valid, wrap, oe;
    logic [7:0] dq_h, dq_d;
    logic [31:0] addr;
    logic [ROW_BITS-1:0] row;
    logic [HP_HI-HP_LO:0] hp;
    logic [BYTE_HI-BYTE_LO:0] bsel;
    logic [15:0] id, regw;
    int err_count = 0;
    int num_checks = 0;
    odl_host_model host (.ck_out(ck), .dq_out(dq_h), .wr_out(wr),
        .rd_out(rd), .reg_out(sp), .dq_in(dq_d), .strobe_in(stb));
    odl_lane_map dut (.SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n),
        .BUS_CLOCK_LINE_IN(ck), .DQ_IN(dq_h), .REG_SPACE_IN(sp),
        .WRITE_EN_IN(wr), .READ_EN_IN(rd), .ADDR_IN(addr),
        .DQ_OUT(dq_d), .DQ_OE_OUT(oe), .READ_WRITE_DATA_STROBE_OUT(stb),
        .READ_WRITE_DATA_STROBE_OE_OUT(), .ROW_OUT(row),
        .HALF_PAGE_OUT(hp), .BYTE_OUT(bsel), .ID_WORD_OUT(id),
        .REG_WORD_OUT(regw), .WORD_VALID_OUT(valid),
        .REFRESH_ROW_OUT(), .REFRESH_WRAP_OUT(wrap));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(posedge sys_clk);
            #1;
            if (s === 1'b1) return;
        end
        err_count++;
        $display("ERROR %0t wait timed out", $time);
        final_report();
    endtask
    task automatic t_addr();
        logic [31:0] t [3] = '{32'hFFFFFFFF, 32'h0055A5A7, 32'h00000000};
        foreach (t[i]) begin
            @(posedge sys_clk);
            addr <= t[i];
            repeat (2) @(posedge sys_clk);
            #1;
            check(32'(row), 32'(t[i][22:10]));
            check(32'(hp), 32'(t[i][9:4]));
            check(32'(bsel), 32'({t[i][3:1], 1'b0}));
        end
        check(32'(id[12:4]), 32'h0C8);
        check(32'h1 << (32'(id[12:8]) + 32'(id[7:4]) + 3), 32'h800000);
        $display("address decode done");
    endtask
    task automatic t_write();
        logic [15:0] w [2] = '{16'hA55A, 16'h3CC3};
        int n;
        foreach (w[i]) begin
            fork
                host.write_word(1'b1, w[i]);
                wait_hi(valid, 40, n);
            join
            @(posedge sys_clk);
            #1;
            check(32'(regw), 32'(w[i]));
            repeat (6) @(posedge sys_clk);
        end
        $display("register write done");
    endtask
    task automatic t_read();
        logic [7:0] hi;
        logic [7:0] lo;
        logic [1:0] s;
        host.read_word(1'b1, hi, lo, s);
        check(32'(hi), 32'h3C);
        check(32'(lo), 32'hC3);
        check(32'(s), 32'h2);
        check(32'(oe), 32'h1);
        $display("register read done");
    endtask
    task automatic t_mem();
        logic [7:0] hi;
        logic [7:0] lo;
        logic [1:0] s;
        int n;
        fork
            host.write_word(1'b0, 16'h12AB);
            wait_hi(valid, 40, n);
        join
        repeat (2) @(posedge sys_clk);
        #1;
        check(32'(regw), 32'h3CC3);
        host.read_word(1'b0, hi, lo, s);
        check(32'({hi, lo}), 32'h12AB);
        $display("memory word done");
    endtask
    task automatic t_refresh();
        int n;
        wait_hi(wrap, 9000, n);
        wait_hi(wrap, 9000, n);
        check(32'(n), 32'h2000);
        $display("refresh done");
    endtask
    initial begin
        rst_n = 1'b0;
        addr = 32'h0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_addr();
        t_write();
        t_read();
        t_mem();
        t_refresh();
        final_report();
    end
endmodule
`default_nettype wire
